// ### lcfs_pkg.sv
package lcfs_pkg;
  localparam int NUM_CH = 4;
  localparam logic [3:0] FAULT_TIMEOUT_PERIODS = 4'h6;
  localparam int SHUTDOWN_LIMIT = 3;
  localparam int SHORT_MARGIN_MV = 8000;
  localparam int VOLT_W = 16;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam int CLK_PERIOD_NS = 20;
  localparam int STARTUP_CHECK_NS = 1000;
  localparam int STARTUP_CHECK_CYC = (STARTUP_CHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {LCFS_ST_CHECK, LCFS_ST_RUN, LCFS_ST_SHORTED, LCFS_ST_LATCHED} lcfs_state_t;
endpackage : lcfs_pkg

// ### lcfs_chan_timer.sv
`timescale 1ns/10ps
module lcfs_chan_timer #(
  parameter logic [3:0] TIMEOUT = lcfs_pkg::FAULT_TIMEOUT_PERIODS
) (
  input wire logic clk_in, // logic clock
  input wire logic sys_rst_in, // async reset, high
  input wire logic fault_in, // fault condition present
  input wire logic period_in, // one pulse per dimming period
  output logic expired_out // timeout reached, pulse
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  wire advance = fault_in && period_in;
  wire hit = advance && (cnt_r == TIMEOUT - 4'h1);
  assign cnt_nxt = !fault_in ? lcfs_pkg::CNT_RESET : (hit ? lcfs_pkg::CNT_RESET : (advance ? cnt_r + 4'h1 : cnt_r));
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      cnt_r <= lcfs_pkg::CNT_RESET;
    else
      cnt_r <= cnt_nxt;
  end
  assign expired_out = hit;
  a_clear_on_gone: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !fault_in |=> cnt_r == 4'h0) else $error("timer not cleared");
  a_expire_count: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    advance && !expired_out |=> cnt_r == $past(cnt_r) + 4'h1) else $error("period not counted");
  a_expire_wrap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    expired_out |=> cnt_r == 4'h0) else $error("timer not restarted after expiry");
endmodule : lcfs_chan_timer

// ### lcfs_supervisor.sv
`timescale 1ns/10ps
// Contract
// - channel above short threshold, no thermal trip: disable after 6 periods
// - short fault with three channels already off shuts all channels (never reached with 4 channels: reference taken over live channels only)
// - channel below short threshold stays enabled even if dissipating
// - open channel lets output reach over-voltage limit, then off after timeout
// - thermal trip disables all channels and boost regulation
// - at over-voltage limit, channels below target time out after 6 periods
// - direct dimming may stretch the timeout beyond 6 periods
// - zener-held open channel stays on; others reaching threshold fault out
// - boost output or switch node shorted at start: never switch
// - short threshold is 8 V above the lowest channel pin voltage
// - channel good on reaching target; good channel dropping below is open
// - after thermal shutdown stay off until enable or power cycled
module lcfs_supervisor #(
  parameter int N = lcfs_pkg::NUM_CH,
  parameter int VW = lcfs_pkg::VOLT_W
) (
  input wire logic clk_in, // 50 MHz logic clock
  input wire logic sys_rst_in, // async reset, high
  input wire logic enable_in, // chip enable, low clears latched shutdown
  input wire logic [N*VW-1:0] channel_pin_voltage_in, // per-channel pin voltage, mV
  input wire logic [N-1:0] at_target_in, // channel current at target
  input wire logic [N-1:0] channel_used_in, // channel not grounded at start
  input wire logic over_voltage_limit_in, // boost output at limit
  input wire logic over_temp_in, // thermal trip comparator
  input wire logic output_shorted_in, // boost output or switch node shorted
  input wire logic pwm_period_in, // pulse at each dimming period start
  input wire logic direct_pwm_in, // direct dimming mode
  output logic [N-1:0] channel_enable_out, // current sink enables
  output logic boost_enable_out, // boost switching enable
  output logic [N-1:0] good_out, // channel good flags
  output logic thermal_latched_out // thermal shutdown held
);
  lcfs_pkg::lcfs_state_t state_r, state_nxt;
  logic [N-1:0] off_r, off_nxt;
  logic [N-1:0] good_r, good_nxt;
  logic [N-1:0] en_r;
  logic boost_r;
  logic thermal_r;
  logic [7:0] chk_r;
  logic dir_phase_r;
  logic [VW-1:0] vmin;
  logic [N-1:0] short_det, open_det, fault_det, expired;

  function automatic logic [VW-1:0] chan_v(input logic [N*VW-1:0] bus, input int i);
    chan_v = bus[i*VW +: VW];
  endfunction : chan_v

  function automatic int count_ones(input logic [N-1:0] v);
    count_ones = 0;
    for (int i = 0; i < N; i++)
      count_ones += int'(v[i]);
  endfunction : count_ones

  // lowest pin voltage among live channels sets the reference
  always_comb
  begin
    vmin = '1;
    for (int i = 0; i < N; i++)
      if (!off_r[i] && chan_v(channel_pin_voltage_in, i) < vmin)
        vmin = chan_v(channel_pin_voltage_in, i);
  end

  wire [VW:0] threshold = {1'b0, vmin} + (VW+1)'(lcfs_pkg::SHORT_MARGIN_MV);
  // direct dimming counts every other period: a slower but safe timeout
  wire period_tick = pwm_period_in && (!direct_pwm_in || dir_phase_r);

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : gen_ch
      assign short_det[g] = !off_r[g]
        && ({1'b0, chan_v(channel_pin_voltage_in, g)} > threshold);
      // good channel losing current, or any live channel below target while output pinned at limit
      assign open_det[g] = !off_r[g] && !at_target_in[g]
        && (good_r[g] || over_voltage_limit_in);
      assign fault_det[g] = short_det[g] || open_det[g];
      lcfs_chan_timer #(
        .TIMEOUT(lcfs_pkg::FAULT_TIMEOUT_PERIODS)
      ) u_timer (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .fault_in(fault_det[g] && state_r == lcfs_pkg::LCFS_ST_RUN),
        .period_in(period_tick),
        .expired_out(expired[g])
      );
    end
  endgenerate

  wire short_trip = |(expired & short_det);
  wire all_off = short_trip && (count_ones(off_r) >= lcfs_pkg::SHUTDOWN_LIMIT);

  always_comb
  begin
    state_nxt = state_r;
    off_nxt = off_r | expired;
    good_nxt = (good_r | at_target_in) & ~off_r;
    if (all_off)
      off_nxt = '1;
    case (state_r)
      lcfs_pkg::LCFS_ST_CHECK:
        if (output_shorted_in)
          state_nxt = lcfs_pkg::LCFS_ST_SHORTED;
        else if (chk_r == 8'(lcfs_pkg::STARTUP_CHECK_CYC))
          state_nxt = lcfs_pkg::LCFS_ST_RUN;
      lcfs_pkg::LCFS_ST_RUN:
        if (over_temp_in)
          state_nxt = lcfs_pkg::LCFS_ST_LATCHED;
      lcfs_pkg::LCFS_ST_SHORTED:
        state_nxt = lcfs_pkg::LCFS_ST_SHORTED;
      lcfs_pkg::LCFS_ST_LATCHED:
        state_nxt = lcfs_pkg::LCFS_ST_LATCHED;
      default:
        state_nxt = lcfs_pkg::LCFS_ST_CHECK;
    endcase
    if (state_r == lcfs_pkg::LCFS_ST_CHECK)
      off_nxt = ~channel_used_in;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= lcfs_pkg::LCFS_ST_CHECK;
      off_r <= '0;
      good_r <= '0;
      chk_r <= 8'h00;
      dir_phase_r <= 1'b0;
    end
    else if (!enable_in)
    begin
      // enable cycling or reset is the only way out of a latched shutdown
      state_r <= lcfs_pkg::LCFS_ST_CHECK;
      off_r <= '0;
      good_r <= '0;
      chk_r <= 8'h00;
      dir_phase_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      off_r <= off_nxt;
      good_r <= good_nxt;
      chk_r <= (state_r == lcfs_pkg::LCFS_ST_CHECK) ? chk_r + 8'h01 : 8'h00;
      dir_phase_r <= pwm_period_in ? !dir_phase_r : dir_phase_r;
    end
  end

  wire running = (state_nxt == lcfs_pkg::LCFS_ST_RUN) && enable_in;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      en_r <= '0;
      boost_r <= 1'b0;
      thermal_r <= 1'b0;
    end
    else
    begin
      en_r <= running ? ~off_nxt : '0;
      boost_r <= running && !(&off_nxt);
      thermal_r <= enable_in && (state_nxt == lcfs_pkg::LCFS_ST_LATCHED);
    end
  end

  assign channel_enable_out = en_r;
  assign boost_enable_out = boost_r;
  assign good_out = good_r;
  assign thermal_latched_out = thermal_r;

  // per-channel checks watch channel 0 or 1; every channel runs the same logic
  a_thermal_all_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_r == lcfs_pkg::LCFS_ST_RUN && over_temp_in && enable_in |=> (channel_enable_out == '0 && !boost_enable_out))
    else $error("thermal trip left outputs on");
  a_thermal_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    thermal_latched_out && enable_in |=> thermal_latched_out && channel_enable_out == '0)
    else $error("thermal shutdown released early");
  a_enable_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !enable_in |=> state_r == lcfs_pkg::LCFS_ST_CHECK && !thermal_latched_out && channel_enable_out == '0)
    else $error("enable low did not clear shutdown");
  a_shorted_no_sw: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_r == lcfs_pkg::LCFS_ST_SHORTED |-> !boost_enable_out)
    else $error("boost switching on shorted output");
  a_start_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_r == lcfs_pkg::LCFS_ST_CHECK |-> channel_enable_out == '0 && !boost_enable_out)
    else $error("outputs on before start check ended");
  a_expire_disables: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_r == lcfs_pkg::LCFS_ST_RUN && |expired && enable_in |=> (off_r & $past(expired)) == $past(expired))
    else $error("expired channel not disabled");
  a_disabled_stays: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_r == lcfs_pkg::LCFS_ST_RUN && enable_in && off_r[0] |=> off_r[0] && !channel_enable_out[0])
    else $error("faulted channel came back");
  // with the reference taken over live channels only, this needs more than four channels
  a_four_short_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    all_off && enable_in |=> off_r == '1)
    else $error("fourth short did not shut all");
  a_few_short_kept: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    short_trip && !all_off && enable_in |=> off_r == ($past(off_r) | $past(expired)))
    else $error("short fault shut healthy channels");
  a_no_fault_kept: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_r == lcfs_pkg::LCFS_ST_RUN && enable_in && !off_r[0] && !fault_det[0] && !all_off |=> !off_r[0])
    else $error("healthy channel disabled");
  a_good_latch: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    enable_in && at_target_in[0] && !off_r[0] |=> good_r[0])
    else $error("good flag not set");
  a_good_cleared: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    off_r[1] |=> !good_out[1])
    else $error("disabled channel still good");
  a_open_detect: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    over_voltage_limit_in && !off_r[1] && !at_target_in[1] |-> open_det[1])
    else $error("limit open not detected");
  a_ref_lowest: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !off_r[0] |-> vmin <= chan_v(channel_pin_voltage_in, 0))
    else $error("reference above a live channel");
  a_tick_normal: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !direct_pwm_in && pwm_period_in |-> period_tick)
    else $error("dimming period not counted");
  a_tick_direct: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    direct_pwm_in && pwm_period_in && !dir_phase_r |-> !period_tick)
    else $error("direct period counted too fast");
endmodule : lcfs_supervisor

// ### lcfs_analog_model.sv
`timescale 1ns/10ps
module lcfs_analog_model (
  input wire logic clk_in, // logic clock
  input wire logic [3:0] chan_en_in, // sink enables from block
  input wire logic [63:0] extra_mv_in, // added pin voltage per channel
  input wire logic [3:0] open_in, // open strings
  output logic [63:0] volt_out, // pin voltages, mV
  output logic [3:0] at_target_out, // current at target
  output logic ovl_out, // output at over-voltage limit
  output logic period_out // dimming period pulse
);
  int cnt = 0;
  // outputs settle at the first falling edge, well inside the reset span
  always @(negedge clk_in)
  begin
    cnt <= (cnt == 19) ? 0 : cnt + 1;
    period_out <= (cnt == 19);
    for (int i = 0; i < 4; i++)
      volt_out[i*16+:16] <= 16'h03E8 + extra_mv_in[i*16+:16];
    // an open string carries no current, an off sink neither
    at_target_out <= chan_en_in & ~open_in;
    // open string pulls the output up to its limit
    ovl_out <= |(chan_en_in & open_in);
  end
endmodule : lcfs_analog_model

// ### led_channel_fault_supervisor_bench.sv
`timescale 1ns/10ps
module led_channel_fault_supervisor_bench;
  logic clk_in = 0, sys_rst_in = 1, enable_in = 1, hot = 0, shorted = 0, direct = 0;
  logic [3:0] used = 4'hF, open_m = 4'h0, en, good, at_t;
  logic [63:0] extra = 64'h0, volt;
  logic ovl, per, boost, therm;
  int n_errors = 0, n_checks = 0;
  initial forever #10 clk_in = ~clk_in;
  lcfs_analog_model model (.clk_in(clk_in), .chan_en_in(en), .extra_mv_in(extra), .open_in(open_m),
    .volt_out(volt), .at_target_out(at_t), .ovl_out(ovl), .period_out(per));
  lcfs_supervisor dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .enable_in(enable_in),
    .channel_pin_voltage_in(volt), .at_target_in(at_t), .channel_used_in(used),
    .over_voltage_limit_in(ovl), .over_temp_in(hot), .output_shorted_in(shorted),
    .pwm_period_in(per), .direct_pwm_in(direct), .channel_enable_out(en),
    .boost_enable_out(boost), .good_out(good), .thermal_latched_out(therm));
  task check(input string what, input logic [4:0] seen, input logic [4:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc
  // enable cycling clears latched state; start check then takes 51 cycles
  task restart(input logic [3:0] om, input logic sh);
    enable_in = 0;
    open_m = om;
    shorted = sh;
    extra = 64'h0;
    hot = 0;
    direct = 0;
    cyc(2);
    enable_in = 1;
    cyc(60);
  endtask : restart
  // model period is 20 cycles: 98 cycles hold at most 5 pulses, 123 at least 6
  task t_short;
    extra[2*16+:16] = 16'h2328;
    cyc(98);
    check("short early", {boost, en}, 5'h1F);
    cyc(25);
    check("short off", {boost, en}, 5'h1B);
    extra[1*16+:16] = 16'h1F40;
    cyc(140);
    check("at margin", {boost, en}, 5'h1B);
  endtask : t_short
  // a grounded channel counts as off; later faults must leave the rest running
  task t_multi;
    used = 4'hE;
    restart(4'h0, 1'h0);
    check("unused off", {boost, en}, 5'h1E);
    extra[2*16+:16] = 16'h2328;
    cyc(123);
    check("first short", {boost, en}, 5'h1A);
    extra[1*16+:16] = 16'h2328;
    cyc(123);
    check("second short", {boost, en}, 5'h18);
    open_m = 4'h8;
    cyc(123);
    check("good lost", {boost, en}, 5'h00);
    check("good cleared", {1'b0, good}, 5'h00);
    used = 4'hF;
  endtask : t_multi
  task t_open;
    restart(4'h1, 0);
    check("good seen", {1'b0, good}, 5'h0E);
    cyc(123);
    check("open off", {boost, en}, 5'h1E);
    check("limit gone", {4'h0, ovl}, 5'h00);
  endtask : t_open
  task t_ovp;
    restart(4'h8, 0);
    cyc(123);
    check("ovp off", {boost, en}, 5'h17);
  endtask : t_ovp
  task t_direct;
    restart(4'h0, 0);
    direct = 1;
    extra[3*16+:16] = 16'h4E20;
    cyc(123);
    check("direct held", {boost, en}, 5'h1F);
    cyc(140);
    check("direct off", {boost, en}, 5'h17);
  endtask : t_direct
  task t_thermal;
    restart(4'h0, 0);
    hot = 1;
    cyc(4);
    check("hot off", {therm, boost, en[2:0]}, 5'h10);
    hot = 0;
    cyc(20);
    check("hot held", {boost, en}, 5'h00);
    restart(4'h0, 0);
    check("hot cleared", {therm, en}, 5'h0F);
  endtask : t_thermal
  task t_shorted;
    restart(4'h0, 1);
    check("no switching", {boost, en}, 5'h00);
    restart(4'h0, 0);
    check("switching", {boost, en}, 5'h1F);
  endtask : t_shorted
  initial
  begin
    cyc(8);
    check("in reset", {boost, en}, 5'h00);
    sys_rst_in = 0;
    cyc(60);
    check("started", {boost, en}, 5'h1F);
    t_short();
    t_multi();
    t_open();
    t_ovp();
    t_direct();
    t_thermal();
    t_shorted();
    stop_test();
  end
  initial
  begin
    cyc(4000);
    n_errors++;
    stop_test();
  end
endmodule : led_channel_fault_supervisor_bench
